// File: verilog/plq_link_quality.sv
/*
  Link quality monitor, latched link events, symbol watchdog, test pattern
  source, data scrambler and decoder memory corruption for a single pair
  gigabit PHY, with its configuration registers.
  Assumes the PCS datapath runs on sys_clk_in, so its signals need no
  synchroniser, and that software uses a one-cycle read and write strobe.
*/
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "plq_defs.svh"

// Operation
// - Fourth test mode alternates the two symbols; select bit sets order.
// - Seventh test mode transmits the data byte of the pattern register.
// - Last link training duration reads back as eight bits in milliseconds.
// - Remote receiver time in upper byte, local receiver time in lower byte.
// - Six-bit link loss count sits in bits fifteen to ten.
// - Ten-bit count of failures without link loss sits in the low bits.
// - Communication ready status reads in bit zero of its register.
// - Channel healthy flag drops on deassertion; a written zero re-arms it.
// - Fault inhibit flag rises on assertion, holds until written zero.
// - Startup detect flag rises on any assertion, cleared by writing zero.
// - Remote error rate flag rises on assertion, cleared by writing zero.
// - Alignment flag records lock loss, written zero sets it, resets zero.
// - Watchdog flag reads zero after low status, written zero sets it.
// - Force enable drives watchdog status to force value, reset value one.
// - Standard watchdog enable starts symbol counters only after link up.
// - Each symbol kind must reach the threshold per window or status drops.
// - Corruption enable XORs nine-bit error value into decoder memory data.
// - Receive delay bit delays descrambler symbol generation by one bit.
// - Transmit delay bit delays scrambler symbol generation by one bit.
// - Receive descrambler uses state bit fourteen, bit zero when inverted.
// - Transmit scrambler uses state bit fourteen, or bit zero when inverted.
// - Bypass bit skips scrambling on both transmit and receive paths.
module plq_link_quality #(
  parameter logic [15:0] MS_CYCLES = 16'(`PLQ_MS_NS / `PLQ_CLK_NS)
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire plq_pkg::plq_addr_t reg_addr_in,
  input wire plq_pkg::plq_data_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output plq_pkg::plq_data_t reg_rdata_out,
  input wire logic [2:0] test_mode_sel_in,
  output logic [1:0] test_symbol_out,
  output logic [7:0] test_data_out,
  input wire logic training_active_in,
  input wire logic local_rcvr_ok_in,
  input wire logic remote_rcvr_ok_in,
  input wire logic link_loss_in,
  input wire logic link_fail_in,
  input wire logic comm_ready_in,
  input wire logic channel_ok_in,
  input wire logic fault_inhibit_in,
  input wire logic startup_detect_in,
  input wire logic remote_error_rate_in,
  input wire logic block_lock_in,
  input wire logic link_up_in,
  input wire logic sym_zero_in,
  input wire logic sym_plus_in,
  input wire logic sym_minus_in,
  input wire logic wd_window_end_in,
  output logic wd_status_out,
  input wire logic [8:0] ecc_mem_data_in,
  output logic [8:0] ecc_mem_data_out,
  input wire logic tx_data_in,
  output logic tx_data_out,
  input wire logic rx_data_in,
  output logic rx_data_out
);
  import plq_pkg::*;

  plq_state_t st_r;
  plq_state_t st_nxt;

  logic wr_tp;
  logic wr_lf;
  logic wr_wd;
  logic wr_sc;
  logic ms_tick;
  logic wd_run;
  logic wd_fail;
  logic [2:0] sym_seen;
  logic tx_sym_now;
  logic rx_sym_now;
  logic tx_sym;
  logic rx_sym;

  assign wr_tp = reg_wr_in && (reg_addr_in == `PLQ_OFF_TEST_PATTERN);
  assign wr_lf = reg_wr_in && (reg_addr_in == `PLQ_OFF_LATCHED);
  assign wr_wd = reg_wr_in && (reg_addr_in == `PLQ_OFF_WATCHDOG);
  assign wr_sc = reg_wr_in && (reg_addr_in == `PLQ_OFF_SCR_ECC);
  assign ms_tick = (st_r.tick_cnt == MS_CYCLES - 16'h0001);
  assign sym_seen = {sym_minus_in, sym_plus_in, sym_zero_in};
  // With the standard enable clear the counters run regardless of link.
  assign wd_run = !st_r.wd_std_en || link_up_in;

  always_comb
  begin
    wd_fail = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      if (st_r.wd_cnt[i] < st_r.watchdog_symbol_threshold)
      begin
        wd_fail = 1'b1;
      end
    end
  end

  assign tx_sym_now = st_r.tx_order_inv ? st_r.tx_lfsr[0]
                                        : st_r.tx_lfsr[14];
  assign rx_sym_now = st_r.rx_order_inv ? st_r.rx_lfsr[0]
                                        : st_r.rx_lfsr[14];
  assign tx_sym = st_r.tx_delay ? st_r.tx_sym_d : tx_sym_now;
  assign rx_sym = st_r.rx_delay ? st_r.rx_sym_d : rx_sym_now;

  always_comb
  begin
    st_nxt = st_r;

    // Register writes.
    if (wr_tp)
    begin
      st_nxt.fourth_pattern_sequence_select = reg_wdata_in[`PLQ_TP_SEQ_BIT];
      st_nxt.mode7_data = reg_wdata_in[`PLQ_TP_DATA_MSB:0];
    end
    if (wr_wd)
    begin
      st_nxt.wd_force_val = reg_wdata_in[`PLQ_WD_FORCE_VAL];
      st_nxt.wd_force_en = reg_wdata_in[`PLQ_WD_FORCE_EN];
      st_nxt.wd_std_en = reg_wdata_in[`PLQ_WD_STD_EN];
      st_nxt.watchdog_symbol_threshold = reg_wdata_in[`PLQ_WD_THR_MSB:0];
    end
    if (wr_sc)
    begin
      st_nxt.ecc_error = reg_wdata_in[`PLQ_SC_ECC_MSB:`PLQ_SC_ECC_LSB];
      st_nxt.ecc_corrupt = reg_wdata_in[`PLQ_SC_ECC_CORRUPT];
      st_nxt.rx_delay = reg_wdata_in[`PLQ_SC_RX_DELAY];
      st_nxt.tx_delay = reg_wdata_in[`PLQ_SC_TX_DELAY];
      st_nxt.rx_order_inv = reg_wdata_in[`PLQ_SC_RX_INV];
      st_nxt.tx_order_inv = reg_wdata_in[`PLQ_SC_TX_INV];
      st_nxt.scr_bypass = reg_wdata_in[`PLQ_SC_BYPASS];
    end

    // Latched flags: a written zero re-arms, and a same-cycle event wins.
    if (wr_lf && !reg_wdata_in[`PLQ_LF_CHANNEL])
    begin
      st_nxt.channel_healthy_latched_low = 1'b1;
    end
    if (!channel_ok_in)
    begin
      st_nxt.channel_healthy_latched_low = 1'b0;
    end
    if (wr_lf && !reg_wdata_in[`PLQ_LF_INHIBIT])
    begin
      st_nxt.fault_inhibit_latched_high = 1'b0;
    end
    if (fault_inhibit_in)
    begin
      st_nxt.fault_inhibit_latched_high = 1'b1;
    end
    if (wr_lf && !reg_wdata_in[`PLQ_LF_STARTUP])
    begin
      st_nxt.startup_detect_latched_high = 1'b0;
    end
    if (startup_detect_in)
    begin
      st_nxt.startup_detect_latched_high = 1'b1;
    end
    if (wr_lf && !reg_wdata_in[`PLQ_LF_ERR_RATE])
    begin
      st_nxt.remote_error_rate_latched_high = 1'b0;
    end
    if (remote_error_rate_in)
    begin
      st_nxt.remote_error_rate_latched_high = 1'b1;
    end
    if (wr_lf && !reg_wdata_in[`PLQ_LF_ALIGN])
    begin
      st_nxt.alignment_latched_low = 1'b1;
    end
    if (!block_lock_in)
    begin
      st_nxt.alignment_latched_low = 1'b0;
    end
    if (wr_lf && !reg_wdata_in[`PLQ_LF_WATCHDOG])
    begin
      st_nxt.symbol_watchdog_latched_low = 1'b1;
    end
    if (!st_r.wd_status)
    begin
      st_nxt.symbol_watchdog_latched_low = 1'b0;
    end

    // Millisecond base and training timing.
    st_nxt.tick_cnt = ms_tick ? 16'h0000 : st_r.tick_cnt + 16'h0001;
    st_nxt.training_d = training_active_in;
    st_nxt.loc_ok_d = local_rcvr_ok_in;
    st_nxt.rem_ok_d = remote_rcvr_ok_in;
    if (training_active_in && !st_r.training_d)
    begin
      st_nxt.ms_elapsed = 8'h00;
      st_nxt.tick_cnt = 16'h0000;
    end
    else if (training_active_in && ms_tick && st_r.ms_elapsed != 8'hff)
    begin
      st_nxt.ms_elapsed = st_r.ms_elapsed + 8'h01;
    end
    if (!training_active_in && st_r.training_d)
    begin
      st_nxt.training_time = st_r.ms_elapsed;
    end
    if (training_active_in && local_rcvr_ok_in && !st_r.loc_ok_d)
    begin
      st_nxt.local_time = st_r.ms_elapsed;
    end
    if (training_active_in && remote_rcvr_ok_in && !st_r.rem_ok_d)
    begin
      st_nxt.remote_time = st_r.ms_elapsed;
    end

    // Drop counters saturate rather than wrap, so a busy link never
    // appears healthy again.
    if (link_loss_in && st_r.loss_cnt != 6'h3f)
    begin
      st_nxt.loss_cnt = st_r.loss_cnt + 6'h01;
    end
    if (link_fail_in && st_r.fail_cnt != 10'h3ff)
    begin
      st_nxt.fail_cnt = st_r.fail_cnt + 10'h001;
    end
    st_nxt.comm_ready = comm_ready_in;

    // Symbol watchdog.
    for (int i = 0; i < 3; i++)
    begin
      if (!wd_run || wd_window_end_in)
      begin
        st_nxt.wd_cnt[i] = 4'h0;
      end
      else if (sym_seen[i] && st_r.wd_cnt[i] != 4'hf)
      begin
        st_nxt.wd_cnt[i] = st_r.wd_cnt[i] + 4'h1;
      end
    end
    if (!wd_run)
    begin
      st_nxt.wd_natural = 1'b1;
    end
    else if (wd_window_end_in)
    begin
      st_nxt.wd_natural = !wd_fail;
    end
    st_nxt.wd_status = st_nxt.wd_force_en ? st_nxt.wd_force_val
                                          : st_nxt.wd_natural;

    // ECC corruption.
    st_nxt.ecc_mem_data = st_r.ecc_corrupt ?
                          (ecc_mem_data_in ^ st_r.ecc_error) :
                          ecc_mem_data_in;

    // Scramblers: the delay tap keeps the previous symbol.
    st_nxt.tx_lfsr = {st_r.tx_lfsr[13:0], ^st_r.tx_lfsr[14:13]};
    st_nxt.rx_lfsr = {st_r.rx_lfsr[13:0], ^st_r.rx_lfsr[14:13]};
    st_nxt.tx_sym_d = tx_sym_now;
    st_nxt.rx_sym_d = rx_sym_now;
    st_nxt.tx_data = tx_data_in ^ (tx_sym & !st_r.scr_bypass);
    st_nxt.rx_data = rx_data_in ^ (rx_sym & !st_r.scr_bypass);

    // Test patterns.
    st_nxt.pattern_phase = 1'b0;
    st_nxt.test_symbol = 2'h0;
    st_nxt.test_data = 8'h00;
    if (test_mode_sel_in == `PLQ_TM_FOURTH)
    begin
      st_nxt.pattern_phase = !st_r.pattern_phase;
      st_nxt.test_symbol = (st_r.pattern_phase ^
                            st_r.fourth_pattern_sequence_select) ?
                           `PLQ_SECOND_PATTERN_SYMBOL :
                           `PLQ_FIRST_PATTERN_SYMBOL;
    end
    if (test_mode_sel_in == `PLQ_TM_SEVENTH)
    begin
      st_nxt.test_data = st_r.mode7_data;
    end

    // Read data stands only in the cycle after the strobe.
    st_nxt.rdata = 16'h0000;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `PLQ_OFF_TEST_PATTERN:
          st_nxt.rdata = {7'h00, st_r.fourth_pattern_sequence_select,
                          st_r.mode7_data};
        `PLQ_OFF_TRAINING:
          st_nxt.rdata = {8'h00, st_r.training_time};
        `PLQ_OFF_RCVR_LOCK:
          st_nxt.rdata = {st_r.remote_time, st_r.local_time};
        `PLQ_OFF_LATCHED:
          st_nxt.rdata = {10'h000, st_r.channel_healthy_latched_low,
                          st_r.fault_inhibit_latched_high,
                          st_r.startup_detect_latched_high,
                          st_r.remote_error_rate_latched_high,
                          st_r.alignment_latched_low,
                          st_r.symbol_watchdog_latched_low};
        `PLQ_OFF_DROP_CNT:
          st_nxt.rdata = {st_r.loss_cnt, st_r.fail_cnt};
        `PLQ_OFF_COMM_READY:
          st_nxt.rdata = {15'h0000, st_r.comm_ready};
        `PLQ_OFF_WATCHDOG:
          st_nxt.rdata = {9'h000, st_r.wd_force_val, st_r.wd_force_en,
                          st_r.wd_std_en, st_r.watchdog_symbol_threshold};
        `PLQ_OFF_SCR_ECC:
          st_nxt.rdata = {1'b0, st_r.ecc_error, st_r.ecc_corrupt,
                          st_r.rx_delay, st_r.tx_delay, st_r.rx_order_inv,
                          st_r.tx_order_inv, st_r.scr_bypass};
        default:
          st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      st_r <= '0;
      st_r.wd_force_val <= 1'(`PLQ_WD_RESET >> `PLQ_WD_FORCE_VAL);
      st_r.wd_std_en <= 1'(`PLQ_WD_RESET >> `PLQ_WD_STD_EN);
      st_r.watchdog_symbol_threshold <= 4'(`PLQ_WD_RESET);
      st_r.wd_natural <= 1'b1;
      st_r.wd_status <= 1'b1;
      st_r.tx_lfsr <= `PLQ_LFSR_SEED;
      st_r.rx_lfsr <= `PLQ_LFSR_SEED;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_out = st_r.rdata;
  assign test_symbol_out = st_r.test_symbol;
  assign test_data_out = st_r.test_data;
  assign wd_status_out = st_r.wd_status;
  assign ecc_mem_data_out = st_r.ecc_mem_data;
  assign tx_data_out = st_r.tx_data;
  assign rx_data_out = st_r.rx_data;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence fourth_held_s;
    (test_mode_sel_in == `PLQ_TM_FOURTH) [*2];
  endsequence

  fourth_alternate_a: assert property (
    fourth_held_s |=> test_symbol_out != $past(test_symbol_out))
    else $error("Fourth test mode did not alternate symbols.");

  seventh_data_a: assert property (
    test_mode_sel_in == `PLQ_TM_SEVENTH |=>
      test_data_out == $past(st_r.mode7_data))
    else $error("Seventh test mode data differs from register.");

  loss_count_a: assert property (
    link_loss_in && st_r.loss_cnt != 6'h3f |=>
      st_r.loss_cnt == $past(st_r.loss_cnt) + 6'h01)
    else $error("Link loss count did not advance.");

  inhibit_sticky_a: assert property (
    fault_inhibit_in |=> st_r.fault_inhibit_latched_high ##1
      (st_r.fault_inhibit_latched_high || $past(wr_lf)))
    else $error("Fault inhibit flag lost without a clear.");

  channel_latch_a: assert property (
    !channel_ok_in ##1 !reg_wr_in |-> !st_r.channel_healthy_latched_low)
    else $error("Channel healthy flag missed a deassertion.");

  watchdog_force_a: assert property (
    st_r.wd_force_en && !wr_wd |=> wd_status_out == $past(st_r.wd_force_val))
    else $error("Forced watchdog status not applied.");

  bypass_path_a: assert property (
    st_r.scr_bypass |=> tx_data_out == $past(tx_data_in) &&
      rx_data_out == $past(rx_data_in))
    else $error("Scrambler bypass did not pass data through.");

  comm_read_a: assert property (
    reg_rd_in && reg_addr_in == `PLQ_OFF_COMM_READY |=>
      reg_rdata_out == {15'h0000, $past(st_r.comm_ready)} ##1
      reg_rdata_out == 16'h0000 || $past(reg_rd_in))
    else $error("Comm ready read data wrong or held too long.");

  ecc_corrupt_a: assert property (
    st_r.ecc_corrupt |=>
      ecc_mem_data_out == ($past(ecc_mem_data_in) ^ $past(st_r.ecc_error)))
    else $error("ECC corruption value not applied.");

endmodule : plq_link_quality

// File: verilog/plq_defs.svh
/*
  Constants of the link quality and PCS configuration register bank:
  register offsets, field positions, reset values and timing counts.
  Assumes it is included by its bare name from the package and the module.
*/
`ifndef PLQ_DEFS_SVH
`define PLQ_DEFS_SVH

`define PLQ_ADDR_W 11
`define PLQ_DATA_W 16

`define PLQ_OFF_TEST_PATTERN 11'h531
`define PLQ_OFF_TRAINING 11'h543
`define PLQ_OFF_RCVR_LOCK 11'h544
`define PLQ_OFF_LATCHED 11'h545
`define PLQ_OFF_DROP_CNT 11'h547
`define PLQ_OFF_COMM_READY 11'h548
`define PLQ_OFF_WATCHDOG 11'h559
`define PLQ_OFF_SCR_ECC 11'h55a

`define PLQ_TP_SEQ_BIT 8
`define PLQ_TP_DATA_MSB 7

`define PLQ_LF_CHANNEL 5
`define PLQ_LF_INHIBIT 4
`define PLQ_LF_STARTUP 3
`define PLQ_LF_ERR_RATE 2
`define PLQ_LF_ALIGN 1
`define PLQ_LF_WATCHDOG 0

`define PLQ_WD_FORCE_VAL 6
`define PLQ_WD_FORCE_EN 5
`define PLQ_WD_STD_EN 4
`define PLQ_WD_THR_MSB 3
`define PLQ_WD_RESET 16'h0051

`define PLQ_SC_ECC_MSB 14
`define PLQ_SC_ECC_LSB 6
`define PLQ_SC_ECC_CORRUPT 5
`define PLQ_SC_RX_DELAY 4
`define PLQ_SC_TX_DELAY 3
`define PLQ_SC_RX_INV 2
`define PLQ_SC_TX_INV 1
`define PLQ_SC_BYPASS 0

`define PLQ_TM_FOURTH 3'h4
`define PLQ_TM_SEVENTH 3'h7
`define PLQ_FIRST_PATTERN_SYMBOL 2'h1
`define PLQ_SECOND_PATTERN_SYMBOL 2'h3
`define PLQ_LFSR_SEED 15'h7fff

`define PLQ_MS_NS 1000000
`define PLQ_CLK_NS 20

`endif

// File: verilog/plq_pkg.sv
/*
  Types of the link quality and PCS configuration register bank.
  Assumes plq_defs.svh is on the include path.
*/
`include "plq_defs.svh"

package plq_pkg;

  typedef logic [`PLQ_ADDR_W-1:0] plq_addr_t;
  typedef logic [`PLQ_DATA_W-1:0] plq_data_t;

  typedef struct packed {
    plq_data_t rdata;
    logic fourth_pattern_sequence_select;
    logic [7:0] mode7_data;
    logic [15:0] tick_cnt;
    logic [7:0] ms_elapsed;
    logic [7:0] training_time;
    logic [7:0] remote_time;
    logic [7:0] local_time;
    logic training_d;
    logic loc_ok_d;
    logic rem_ok_d;
    logic [5:0] loss_cnt;
    logic [9:0] fail_cnt;
    logic comm_ready;
    logic channel_healthy_latched_low;
    logic fault_inhibit_latched_high;
    logic startup_detect_latched_high;
    logic remote_error_rate_latched_high;
    logic alignment_latched_low;
    logic symbol_watchdog_latched_low;
    logic wd_force_val;
    logic wd_force_en;
    logic wd_std_en;
    logic [3:0] watchdog_symbol_threshold;
    logic [2:0][3:0] wd_cnt;
    logic wd_natural;
    logic wd_status;
    logic [8:0] ecc_error;
    logic ecc_corrupt;
    logic rx_delay;
    logic tx_delay;
    logic rx_order_inv;
    logic tx_order_inv;
    logic scr_bypass;
    logic [14:0] tx_lfsr;
    logic [14:0] rx_lfsr;
    logic tx_sym_d;
    logic rx_sym_d;
    logic tx_data;
    logic rx_data;
    logic [8:0] ecc_mem_data;
    logic pattern_phase;
    logic [1:0] test_symbol;
    logic [7:0] test_data;
  } plq_state_t;

endpackage : plq_pkg

// File: bench/plq_far_end.sv
/*
  Far end of the datapath: a random receive bit stream, and bursts of
  symbols, one every other cycle, closed by one window end pulse.
  Assumes one clock shared with the register bank and an active low reset.
*/
`timescale 1ns/1ps
module plq_far_end (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] burst_in,
  input wire logic go_in,
  output logic rx_bit_out,
  output logic zero_out,
  output logic plus_out,
  output logic minus_out,
  output logic window_end_out
);
  logic [4:0] left_r;
  logic run_r;
  int seed = 30;
  // Symbols come with gaps, so a counter that only counts runs is caught.
  always @(posedge sys_clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      left_r <= 5'h00;
      run_r <= 1'b0;
      {zero_out, plus_out, minus_out, window_end_out} <= 4'h0;
    end
    else
    begin
      {zero_out, plus_out, minus_out} <= {3{run_r & left_r[0]}};
      window_end_out <= run_r && left_r == 5'h00;
      if (go_in)
      begin
        run_r <= 1'b1;
        left_r <= {burst_in, 1'b0};
      end
      else if (left_r != 5'h00)
        left_r <= left_r - 5'h01;
      else
        run_r <= 1'b0;
    end
  always @(posedge sys_clk_in)
    rx_bit_out <= 1'($random(seed));
endmodule : plq_far_end

// File: bench/plq_link_quality_test.sv
/*
  Self-checking bench of the link quality register bank.
  Assumes plq_pkg, plq_link_quality and plq_far_end are compiled first.
*/
`timescale 1ns/1ps
`include "plq_defs.svh"
module plq_link_quality_test;
  import plq_pkg::*;
  localparam int MS = 10;
  localparam plq_addr_t ADR [8] = '{`PLQ_OFF_TEST_PATTERN,
    `PLQ_OFF_TRAINING, `PLQ_OFF_RCVR_LOCK, `PLQ_OFF_LATCHED,
    `PLQ_OFF_DROP_CNT, `PLQ_OFF_COMM_READY, `PLQ_OFF_WATCHDOG,
    `PLQ_OFF_SCR_ECC};
  localparam plq_data_t MSK [8] = '{16'h01ff, 16'h0, 16'h0, 16'h0,
    16'h0, 16'h0, 16'h007f, 16'h7fff};
  logic sys_clk_in = 0, rst_b_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  plq_addr_t reg_addr_in = '0;
  plq_data_t reg_wdata_in = '0, reg_rdata_out, d, e;
  logic training_active_in = 0, local_rcvr_ok_in = 0;
  logic remote_rcvr_ok_in = 0, link_loss_in = 0, link_fail_in = 0;
  logic comm_ready_in = 0, channel_ok_in = 1, fault_inhibit_in = 0;
  logic startup_detect_in = 0, remote_error_rate_in = 0;
  logic block_lock_in = 1, link_up_in = 0, tx_data_in = 0, go = 0;
  logic tx_data_out, rx_data_in, rx_data_out, wd_status_out;
  logic sym_zero_in, sym_plus_in, sym_minus_in, wd_window_end_in;
  logic [2:0] test_mode_sel_in = 0;
  logic [1:0] test_symbol_out;
  logic [7:0] test_data_out;
  logic [8:0] ecc_mem_data_in = 0, ecc_mem_data_out;
  logic [3:0] burst = 0;
  logic [31:0] kt = 0, kr = 0;
  logic pt = 0, pr = 0;
  int mismatches = 0, comparisons = 0, seed = 30;
  always #10 sys_clk_in = ~sys_clk_in;
  plq_link_quality #(.MS_CYCLES(16'(MS))) DUT (.sys_clk_in, .rst_b_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .test_mode_sel_in, .test_symbol_out, .test_data_out,
    .training_active_in, .local_rcvr_ok_in, .remote_rcvr_ok_in,
    .link_loss_in, .link_fail_in, .comm_ready_in, .channel_ok_in,
    .fault_inhibit_in, .startup_detect_in, .remote_error_rate_in,
    .block_lock_in, .link_up_in, .sym_zero_in, .sym_plus_in,
    .sym_minus_in, .wd_window_end_in, .wd_status_out, .ecc_mem_data_in,
    .ecc_mem_data_out, .tx_data_in, .tx_data_out, .rx_data_in,
    .rx_data_out);
  plq_far_end FAR (.sys_clk_in, .rst_b_in, .burst_in(burst), .go_in(go),
    .rx_bit_out(rx_data_in), .zero_out(sym_zero_in),
    .plus_out(sym_plus_in), .minus_out(sym_minus_in),
    .window_end_out(wd_window_end_in));
  // Keystreams are compared path against path, so no LFSR phase is guessed.
  always @(posedge sys_clk_in)
  begin
    kt <= {kt[30:0], tx_data_out ^ pt};
    kr <= {kr[30:0], rx_data_out ^ pr};
    pt <= tx_data_in;
    pr <= rx_data_in;
    tx_data_in <= 1'($random(seed));
  end
  task automatic close_out;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons,
      mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input plq_data_t got, input plq_data_t exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic plq_data_t ecc_exp(input logic [8:0] v,
    input logic [8:0] err, input logic on);
    return 16'(on ? v ^ err : v);
  endfunction : ecc_exp
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : cyc
  task automatic wr(input plq_addr_t a, input plq_data_t v);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rdchk(input plq_addr_t a, input plq_data_t exp);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, exp);
  endtask : rdchk
  task automatic win(input logic [3:0] n, input logic ok);
    int i;
    @(posedge sys_clk_in);
    burst <= n;
    go <= 1'b1;
    @(posedge sys_clk_in);
    go <= 1'b0;
    for (i = 0; i < 50 && wd_window_end_in !== 1'b1; i++)
      @(posedge sys_clk_in);
    if (i == 50)
    begin
      mismatches++;
      $display("Error at %0t: no window end", $time);
      close_out();
    end
    cyc(3);
    #1 chk(16'(wd_status_out), 16'(ok));
  endtask : win
  task automatic scr(input plq_data_t c);
    wr(`PLQ_OFF_SCR_ECC, c);
    cyc(40);
  endtask : scr
  initial
  begin
    cyc(16);
    rst_b_in <= 1'b1;
    #1 chk(16'(wd_status_out), 16'h1);
    foreach (ADR[i])
      rdchk(ADR[i], i == 6 ? `PLQ_WD_RESET : 16'h0);
    foreach (ADR[i])
    begin
      d = 16'($random(seed));
      if (i != 3)
        wr(ADR[i], d);
      rdchk(ADR[i], d & MSK[i]);
    end
    wr(11'h532, 16'hffff);
    rdchk(11'h532, 16'h0);
    wr(`PLQ_OFF_WATCHDOG, `PLQ_WD_RESET);
    wr(`PLQ_OFF_SCR_ECC, 16'h0);
    $display("register test done");
    d = 16'($random(seed));
    wr(`PLQ_OFF_TEST_PATTERN, d & 16'h00ff);
    cyc(1);
    test_mode_sel_in <= `PLQ_TM_SEVENTH;
    cyc(2);
    #1 chk(16'(test_data_out), d & 16'h00ff);
    for (int s = 0; s < 2; s++)
    begin
      cyc(1);
      test_mode_sel_in <= 3'h0;
      wr(`PLQ_OFF_TEST_PATTERN, 16'(s) << 8);
      cyc(1);
      test_mode_sel_in <= `PLQ_TM_FOURTH;
      #1;
      repeat (8)
        if (test_symbol_out === 2'h0)
          #20;
      chk(16'(test_symbol_out), s ? 16'h3 : 16'h1);
      #20 chk(16'(test_symbol_out), s ? 16'h1 : 16'h3);
    end
    cyc(1);
    test_mode_sel_in <= 3'h0;
    $display("test pattern test done");
    d = 16'(($random(seed) & 15) + 1);
    link_loss_in <= 1'b1;
    comm_ready_in <= 1'b1;
    cyc(70);
    link_loss_in <= 1'b0;
    link_fail_in <= 1'b1;
    cyc(d);
    link_fail_in <= 1'b0;
    rdchk(`PLQ_OFF_DROP_CNT, 16'hfc00 | d);
    rdchk(`PLQ_OFF_COMM_READY, 16'h1);
    cyc(1);
    training_active_in <= 1'b1;
    cyc(2 * MS + 5);
    local_rcvr_ok_in <= 1'b1;
    cyc(2 * MS);
    remote_rcvr_ok_in <= 1'b1;
    cyc(2 * MS);
    training_active_in <= 1'b0;
    rdchk(`PLQ_OFF_TRAINING, 16'h0006);
    rdchk(`PLQ_OFF_RCVR_LOCK, 16'h0402);
    $display("link quality test done");
    wr(`PLQ_OFF_LATCHED, 16'h0);
    rdchk(`PLQ_OFF_LATCHED, 16'h0023);
    cyc(1);
    {channel_ok_in, block_lock_in} <= 2'b00;
    {fault_inhibit_in, startup_detect_in, remote_error_rate_in} <= 3'h7;
    cyc(1);
    {channel_ok_in, block_lock_in} <= 2'b11;
    {fault_inhibit_in, startup_detect_in, remote_error_rate_in} <= 3'h0;
    cyc(1);
    e = 16'h001d;
    rdchk(`PLQ_OFF_LATCHED, e);
    for (int b = 0; b < 6; b++)
    begin
      wr(`PLQ_OFF_LATCHED, ~(16'h1 << b));
      e = (e & ~(16'h1 << b)) | (16'h0023 & (16'h1 << b));
      rdchk(`PLQ_OFF_LATCHED, e);
    end
    $display("latched flag test done");
    win(4'h0, 1'b1);
    cyc(1);
    link_up_in <= 1'b1;
    win(4'h0, 1'b0);
    rdchk(`PLQ_OFF_LATCHED, 16'h0022);
    win(4'h1, 1'b1);
    wr(`PLQ_OFF_WATCHDOG, 16'h0053);
    win(4'h2, 1'b0);
    win(4'h3, 1'b1);
    cyc(1);
    link_up_in <= 1'b0;
    wr(`PLQ_OFF_WATCHDOG, 16'h0043);
    win(4'h2, 1'b0);
    wr(`PLQ_OFF_WATCHDOG, 16'h0063);
    cyc(3);
    #1 chk(16'(wd_status_out), 16'h1);
    wr(`PLQ_OFF_WATCHDOG, 16'h0023);
    win(4'h3, 1'b0);
    $display("watchdog test done");
    for (int c = 0; c < 2; c++)
    begin
      d = 16'($random(seed));
      wr(`PLQ_OFF_SCR_ECC, {1'b0, d[8:0], 1'(c), 5'h00});
      cyc(1);
      ecc_mem_data_in <= d[15:7];
      cyc(2);
      #1 chk(16'(ecc_mem_data_out), ecc_exp(d[15:7], d[8:0], 1'(c)));
    end
    scr(16'h0000);
    chk(kt[15:0], kr[15:0]);
    chk(16'(kt[15:0] == 16'h0), 16'h0);
    scr(16'h0002);
    chk(kr[15:0], kt[29:14]);
    scr(16'h0004);
    chk(kt[15:0], kr[29:14]);
    scr(16'h0008);
    chk(kt[15:0], kr[16:1]);
    scr(16'h0010);
    chk(kr[15:0], kt[16:1]);
    scr(16'h0001);
    chk(kt[15:0] | kr[15:0], 16'h0);
    $display("scrambler test done");
    close_out();
  end
endmodule : plq_link_quality_test
